// ===== clm_pkg.sv
package clm_pkg;

	// ---------------------------------------------------------------
	// Bank map
	// ---------------------------------------------------------------
	localparam int          NUM_CHAN           = 4;
	localparam int          BANKS_PER_CHAN     = 3;
	localparam int          NUM_CHAN_BANKS     = 12;
	localparam int          NUM_GLOBAL_BANKS   = 3;
	localparam logic [3:0]  BANK_GLOBAL_FIRST  = 4'hC;
	localparam logic [3:0]  BANK_LIVE_DYNAMIC  = 4'hE;
	localparam logic [3:0]  BANK_MASK          = 4'hF;
	localparam int          ROLE_RX_STATIC     = 0;
	localparam int          ROLE_TX_STATIC     = 1;
	localparam int          ROLE_DYNAMIC       = 2;

	// ---------------------------------------------------------------
	// Field layout
	// ---------------------------------------------------------------
	localparam int          BIT_BCAST_ENABLE   = 0;
	localparam int          BIT_FORCE_BCAST    = 0;
	localparam int          RFMODE_LSB         = 1;
	localparam int          RFMODE_WIDTH       = 2;
	localparam int          BIT_FRAMING_CHAR   = 3;
	localparam int          OFFSET_WIDTH       = 4;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [7:0]  RST_MASK           = 8'hFF;
	localparam logic [7:0]  RST_RX_STATIC      = 8'h0D;
	localparam logic [7:0]  RST_TX_STATIC      = 8'h01;
	localparam logic [7:0]  RST_DYNAMIC        = 8'h01;
	localparam logic [7:0]  RST_GLOBAL         = 8'h00;

	// ---------------------------------------------------------------
	// Framer modes and timing
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		CLM_RF_LOW_LATENCY = 2'h0,
		CLM_RF_ADJACENT4   = 2'h1,
		CLM_RF_PAIR_SPAN   = 2'h2,
		CLM_RF_TEST        = 2'h3
	} clm_rfmode_t;

	localparam int          CHAR_BITS          = 10;
	localparam int          SPAN_BITS          = 50;
	localparam logic [2:0]  SPAN_CHARS         = 3'(SPAN_BITS / CHAR_BITS);
	localparam logic [2:0]  ADJACENT_NEEDED    = 3'h4;
	localparam logic [2:0]  COUNT_ONE          = 3'h1;
	localparam logic [2:0]  COUNT_MAX          = 3'h7;

endpackage

// ===== clm_framer_ctl.sv
`timescale 1ns/1ns
module clm_framer_ctl (
	input  wire logic                                sys_clk,
	input  wire logic                                reset,
	input  wire logic [1:0]                          reframeModeSel,
	input  wire logic                                framingCharSel,
	input  wire logic                                charStrobe,
	input  wire logic                                k28Hit,
	input  wire logic                                commaHit,
	input  wire logic [clm_pkg::OFFSET_WIDTH-1:0]    hitOffset,
	output logic                                     realign,
	output logic [clm_pkg::OFFSET_WIDTH-1:0]         alignOffset,
	output logic                                     stretchClock
);

	// ---------------------------------------------------------------
	// Hit selection and run tracking
	// ---------------------------------------------------------------
	logic [clm_pkg::OFFSET_WIDTH-1:0] lastOffset;
	logic [2:0]                       runCount;
	logic [2:0]                       charsSince;
	logic                             havePending;

	wire clm_pkg::clm_rfmode_t mode     = clm_pkg::clm_rfmode_t'(reframeModeSel);
	wire hit         = framingCharSel ? k28Hit : commaHit;              // R17 R18
	wire sameOffset  = hit && havePending && (hitOffset == lastOffset);
	wire [2:0] next_runCount = !hit ? 3'h0 :
		(sameOffset && runCount != 3'h0) ?
		((runCount == clm_pkg::COUNT_MAX) ? runCount : 3'(runCount + 3'h1)) :
		clm_pkg::COUNT_ONE;
	wire [2:0] next_charsSince = (charsSince == clm_pkg::COUNT_MAX) ?
		charsSince : 3'(charsSince + 3'h1);

	// Pair must fit inside one span: second hit fewer than SPAN_CHARS characters later
	wire pairFound   = sameOffset && (charsSince < clm_pkg::SPAN_CHARS);  // R14
	wire adjFound    = hit && (next_runCount == clm_pkg::ADJACENT_NEEDED); // R13

	logic doAlign;
	always_comb begin
		unique case (mode)
			clm_pkg::CLM_RF_LOW_LATENCY: doAlign = hit;   // R12
			clm_pkg::CLM_RF_ADJACENT4:   doAlign = adjFound;
			clm_pkg::CLM_RF_PAIR_SPAN:   doAlign = pairFound;
			clm_pkg::CLM_RF_TEST:        doAlign = 1'b0;  // R16
		endcase
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			lastOffset  <= '0;
			runCount    <= 3'h0;
			charsSince  <= 3'h0;
			havePending <= 1'b0;
		end else if (charStrobe) begin
			runCount   <= next_runCount;
			charsSince <= hit ? clm_pkg::COUNT_ONE : next_charsSince;
			if (hit) begin
				lastOffset  <= hitOffset;
				havePending <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			realign      <= 1'b0;
			alignOffset  <= '0;
			stretchClock <= 1'b0;
		end else begin
			realign      <= charStrobe && doAlign;
			// Multi-byte modes keep the character clock phase
			stretchClock <= charStrobe && doAlign
				&& (mode == clm_pkg::CLM_RF_LOW_LATENCY);      // R12 R15
			if (charStrobe && doAlign) begin
				alignOffset <= hitOffset;
			end
		end
	end

endmodule // clm_framer_ctl

// ===== clm_config_latch.sv
// Operation
// R1 - Strobe low latches data into addressed bank
// R2 - Banks 12-14 broadcast to every third bank
// R3 - Broadcast never alters channel enable bit zero
// R4 - Force bit updates targets despite enable bits
// R5 - Mask bank gates update bit by bit
// R6 - Mask bank resets to all ones
// R7 - Mask bank writes are never masked
// R8 - Force works whatever mask bit zero holds
// R9 - Three banks per channel: rx, tx, dynamic
// R10 - Held address 1110 gives live dynamic controls
// R11 - Reframe mode resets to paired-character framer
// R12 - Mode 00 reframes every hit, stretching clock
// R13 - Mode 01 needs four adjacent aligned hits
// R14 - Mode 10 needs two hits within 50 bits
// R15 - Multi-byte modes keep character clock phase
// R16 - Host must not program reframe mode 11
// R17 - Framing select one, reset one: K28.5
// R18 - Framing select zero: comma portion only
// R19 - Mask applies to direct and broadcast writes
`timescale 1ns/1ns
module clm_config_latch (
	input  wire logic          sys_clk,
	input  wire logic          reset,
	input  wire logic          latch_write_strobe_n,
	input  wire logic [3:0]    bankAddr,
	input  wire logic [7:0]    bankData,
	input  wire logic [3:0]    charStrobe,
	input  wire logic [3:0]    k28Hit,
	input  wire logic [3:0]    commaHit,
	input  wire logic [15:0]   hitOffset,
	output logic      [31:0]   rxStaticCfg,
	output logic      [31:0]   txStaticCfg,
	output logic      [31:0]   dynamicCfg,
	output logic      [23:0]   globalCfg,
	output logic      [7:0]    updateMask,
	output logic      [7:0]    reframeModeSel,
	output logic      [3:0]    framingCharSel,
	output logic      [3:0]    realign,
	output logic      [15:0]   alignOffset,
	output logic      [3:0]    stretchClock
);

	// ---------------------------------------------------------------
	// Write decode
	// ---------------------------------------------------------------
	logic [7:0] chanBank   [0:clm_pkg::NUM_CHAN_BANKS-1];
	logic [7:0] globalBank [0:clm_pkg::NUM_GLOBAL_BANKS-1];

	// A held strobe writes every cycle, so bank 14 tracks the data pins
	wire        writeActive  = !latch_write_strobe_n;                         // R1 R10
	wire        maskWrite    = writeActive && (bankAddr == clm_pkg::BANK_MASK);
	wire        globalWrite  = writeActive && (bankAddr >= clm_pkg::BANK_GLOBAL_FIRST)
		&& (bankAddr != clm_pkg::BANK_MASK);
	wire        forceBcast   = bankData[clm_pkg::BIT_FORCE_BCAST];           // R4 R8
	wire [7:0]  maskedKeep   = ~updateMask;
	wire [7:0]  maskedTake   = bankData & updateMask;                         // R5 R19
	wire [7:0]  enableBitSel = 8'h01 << clm_pkg::BIT_BCAST_ENABLE;

	// ---------------------------------------------------------------
	// Channel banks
	// ---------------------------------------------------------------
	genvar gb;
	generate
		for (gb = 0; gb < clm_pkg::NUM_CHAN_BANKS; gb++) begin : g_chan_bank
			localparam int         ROLE       = gb % clm_pkg::BANKS_PER_CHAN;
			localparam int         CHAN       = gb / clm_pkg::BANKS_PER_CHAN;
			localparam logic [3:0] OWN_ADDR   = 4'(gb);
			localparam logic [3:0] BCAST_ADDR = 4'(clm_pkg::BANK_GLOBAL_FIRST + 4'(ROLE));
			localparam logic [7:0] RST_VALUE  =
				(ROLE == clm_pkg::ROLE_RX_STATIC) ? clm_pkg::RST_RX_STATIC :
				(ROLE == clm_pkg::ROLE_TX_STATIC) ? clm_pkg::RST_TX_STATIC :
				clm_pkg::RST_DYNAMIC;                                         // R9

			wire directHit = writeActive && (bankAddr == OWN_ADDR);
			wire bcastHit  = writeActive && (bankAddr == BCAST_ADDR)
				&& (chanBank[gb][clm_pkg::BIT_BCAST_ENABLE] || forceBcast);   // R2 R4
			wire [7:0] merged = (chanBank[gb] & maskedKeep) | maskedTake;    // R5 R19
			// Broadcast leaves the channel enable bit as it was
			wire [7:0] bcastValue = (merged & ~enableBitSel)
				| (chanBank[gb] & enableBitSel);                              // R3 R4
			wire [7:0] next_bank = directHit ? merged :
				bcastHit ? bcastValue : chanBank[gb];

			always_ff @(posedge sys_clk) begin
				if (reset) begin
					chanBank[gb] <= RST_VALUE;                                // R11 R17
				end else begin
					chanBank[gb] <= next_bank;
				end
			end

			if (ROLE == clm_pkg::ROLE_RX_STATIC) begin : g_rx
				assign rxStaticCfg[CHAN*8 +: 8] = chanBank[gb];
				assign reframeModeSel[CHAN*2 +: 2] =
					chanBank[gb][clm_pkg::RFMODE_LSB +: clm_pkg::RFMODE_WIDTH];
				assign framingCharSel[CHAN] = chanBank[gb][clm_pkg::BIT_FRAMING_CHAR];
			end else if (ROLE == clm_pkg::ROLE_TX_STATIC) begin : g_tx
				assign txStaticCfg[CHAN*8 +: 8] = chanBank[gb];
			end else begin : g_dyn
				assign dynamicCfg[CHAN*8 +: 8] = chanBank[gb];
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// Global banks
	// ---------------------------------------------------------------
	genvar gg;
	generate
		for (gg = 0; gg < clm_pkg::NUM_GLOBAL_BANKS; gg++) begin : g_global_bank
			localparam logic [3:0] OWN_ADDR = 4'(clm_pkg::BANK_GLOBAL_FIRST + 4'(gg));

			wire ownHit = globalWrite && (bankAddr == OWN_ADDR);
			// Force bit is stored unmasked so mask bit zero cannot block it
			wire [7:0] merged = (globalBank[gg] & maskedKeep) | maskedTake;
			wire [7:0] next_bank = !ownHit ? globalBank[gg] :
				((merged & ~enableBitSel) | (bankData & enableBitSel));      // R8

			always_ff @(posedge sys_clk) begin
				if (reset) begin
					globalBank[gg] <= clm_pkg::RST_GLOBAL;
				end else begin
					globalBank[gg] <= next_bank;
				end
			end

			assign globalCfg[gg*8 +: 8] = globalBank[gg];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Mask bank
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			updateMask <= clm_pkg::RST_MASK;                                  // R6
		end else if (maskWrite) begin
			updateMask <= bankData;                                           // R7
		end
	end

	// ---------------------------------------------------------------
	// Per-channel framer control
	// ---------------------------------------------------------------
	genvar gc;
	generate
		for (gc = 0; gc < clm_pkg::NUM_CHAN; gc++) begin : g_framer
			clm_framer_ctl u_framer (
				.sys_clk        (sys_clk),
				.reset          (reset),
				.reframeModeSel (reframeModeSel[gc*2 +: 2]),
				.framingCharSel (framingCharSel[gc]),
				.charStrobe     (charStrobe[gc]),
				.k28Hit         (k28Hit[gc]),
				.commaHit       (commaHit[gc]),
				.hitOffset      (hitOffset[gc*4 +: 4]),
				.realign        (realign[gc]),
				.alignOffset    (alignOffset[gc*4 +: 4]),
				.stretchClock   (stretchClock[gc])
			);
		end
	endgenerate

endmodule // clm_config_latch

// ===== clm_config_latch_checker.sv
`timescale 1ns/1ns
module clm_config_latch_checker (
	input wire logic        sys_clk,
	input wire logic        reset,
	input wire logic        latch_write_strobe_n,
	input wire logic [3:0]  bankAddr,
	input wire logic [7:0]  bankData,
	input wire logic [3:0]  charStrobe,
	input wire logic [3:0]  k28Hit,
	input wire logic [3:0]  commaHit,
	input wire logic [15:0] hitOffset,
	input wire logic [31:0] rxStaticCfg,
	input wire logic [31:0] txStaticCfg,
	input wire logic [31:0] dynamicCfg,
	input wire logic [23:0] globalCfg,
	input wire logic [7:0]  updateMask,
	input wire logic [7:0]  reframeModeSel,
	input wire logic [3:0]  framingCharSel,
	input wire logic [3:0]  realign,
	input wire logic [15:0] alignOffset,
	input wire logic [3:0]  stretchClock
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	wire logic       wrTaken    = !latch_write_strobe_n;
	wire logic       hitSel     = framingCharSel[0] ? k28Hit[0] : commaHit[0];
	wire logic [7:0] keepMask   = ~updateMask;
	wire logic [7:0] maskedData = bankData & updateMask;
	wire logic [3:0] rxEn       = {rxStaticCfg[24], rxStaticCfg[16],
		rxStaticCfg[8], rxStaticCfg[0]};
	wire logic [6:0] rx3Next    = (rxStaticCfg[31:25] & keepMask[7:1]) | maskedData[7:1];
	wire logic [6:0] dyn0Next   = (dynamicCfg[7:1] & keepMask[7:1]) | maskedData[7:1];
	wire logic [7:0] rx1Next    = (rxStaticCfg[15:8] & keepMask) | maskedData;
	wire logic [3:0] hitOff0    = hitOffset[3:0];
	a_mask_reset_ones: assert property ($fell(reset) |-> updateMask == 8'hFF)
		else $error("mask not all ones after reset");
	a_mode_reset_vals: assert property (
		$fell(reset) |-> reframeModeSel == 8'hAA && framingCharSel == 4'hF)
		else $error("framer selects wrong after reset");
	a_mask_write_full: assert property (
		wrTaken && bankAddr == 4'hF |=> updateMask == $past(bankData))
		else $error("mask write was gated");
	a_direct_masked: assert property (
		wrTaken && bankAddr == 4'h3 |=> rxStaticCfg[15:8] == $past(rx1Next))
		else $error("direct write not masked bitwise");
	a_bcast_keeps_en: assert property (wrTaken && bankAddr == 4'hC |=> $stable(rxEn))
		else $error("broadcast changed enable bits");
	a_bcast_gated: assert property (
		wrTaken && bankAddr == 4'hD && !bankData[0] && !txStaticCfg[8]
		|=> $stable(txStaticCfg[15:8]))
		else $error("disabled bank took broadcast");
	a_force_update: assert property (
		wrTaken && bankAddr == 4'hC && bankData[0]
		|=> rxStaticCfg[31:25] == $past(rx3Next))
		else $error("forced broadcast missed target");
	a_live_dynamic: assert property (
		wrTaken && bankAddr == 4'hE && dynamicCfg[0]
		|=> dynamicCfg[7:1] == $past(dyn0Next))
		else $error("dynamic bank not following data");
	a_low_latency: assert property (
		charStrobe[0] && hitSel && reframeModeSel[1:0] == 2'h0
		|=> realign[0] && stretchClock[0] && alignOffset[3:0] == $past(hitOff0))
		else $error("low latency framer missed hit");
	a_phase_kept: assert property (
		realign[0] && $past(reframeModeSel[1:0]) != 2'h0 |-> !stretchClock[0])
		else $error("multi byte framer stretched clock");
	c_force: cover property (wrTaken && bankAddr == 4'hC && bankData[0]);
	c_stretch: cover property (realign[0] && stretchClock[0]);
	c_live: cover property (wrTaken && bankAddr == 4'hE ##1 wrTaken && bankAddr == 4'hE);
endmodule // clm_config_latch_checker

bind clm_config_latch clm_config_latch_checker u_chk (
	.sys_clk, .reset, .latch_write_strobe_n, .bankAddr, .bankData, .charStrobe, .k28Hit,
	.commaHit, .hitOffset, .rxStaticCfg, .txStaticCfg, .dynamicCfg, .globalCfg, .updateMask,
	.reframeModeSel, .framingCharSel, .realign, .alignOffset, .stretchClock
);

// ===== clm_host_model.sv
`timescale 1ns/1ns
module clm_host_model (
	input  wire logic       sys_clk,
	output logic            latch_write_strobe_n,
	output logic [3:0]      bankAddr,
	output logic [7:0]      bankData
);
	initial begin
		latch_write_strobe_n = 1'b1;
		bankAddr = 4'h0;
		bankData = 8'h00;
	end
	// Hold keeps the strobe low so the data lines act as live controls
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input bit hold);
		@(posedge sys_clk);
		latch_write_strobe_n <= 1'b0;
		bankAddr <= a;
		bankData <= d;
		@(posedge sys_clk);
		if (!hold) begin
			latch_write_strobe_n <= 1'b1;
			bankAddr <= ~a;
			bankData <= ~d;
		end
	endtask
endmodule // clm_host_model

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        sys_clk, reset, latch_write_strobe_n;
	logic [3:0]  bankAddr, charStrobe, k28Hit, commaHit, realign, framingCharSel, stretchClock;
	logic [7:0]  bankData, updateMask, reframeModeSel;
	logic [15:0] hitOffset, alignOffset;
	logic [31:0] rxStaticCfg, txStaticCfg, dynamicCfg;
	logic [23:0] globalCfg;
	int          n_mismatch, samples_checked;

	clm_host_model host (.sys_clk, .latch_write_strobe_n, .bankAddr, .bankData);
	clm_config_latch dut (
		.sys_clk, .reset, .latch_write_strobe_n, .bankAddr, .bankData, .charStrobe, .k28Hit,
		.commaHit, .hitOffset, .rxStaticCfg, .txStaticCfg, .dynamicCfg, .globalCfg, .updateMask,
		.reframeModeSel, .framingCharSel, .realign, .alignOffset, .stretchClock
	);

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic w(input logic [3:0] a, input logic [7:0] d, input bit hold);
		host.wr(a, d, hold);
		@(posedge sys_clk);
		#1;
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		$display("MISMATCH at %0t: run did not finish", $time);
		conclude();
	end

	initial begin
		reset = 1'b1;
		charStrobe = 4'h0;
		k28Hit = 4'h0;
		commaHit = 4'h0;
		hitOffset = 16'h0000;
		repeat (16) @(posedge sys_clk);
		reset <= 1'b0;
		@(posedge sys_clk);
		#1;
		check(updateMask, 32'h0000_00FF, "mask reset");
		check(rxStaticCfg, 32'h0D0D_0D0D, "rx reset");
		check(dynamicCfg, 32'h0101_0101, "dynamic reset");
		$display("test reset done");
		w(4'hF, 8'hF0, 0);
		check(updateMask, 32'h0000_00F0, "mask write");
		w(4'h3, 8'hFF, 0);
		check(rxStaticCfg[15:8], 32'h0000_00FD, "masked write");
		w(4'hF, 8'h0F, 0);
		w(4'hF, 8'hFF, 0);
		check(updateMask, 32'h0000_00FF, "mask unmaskable");
		$display("test mask done");
		w(4'h4, 8'h00, 0);
		w(4'hD, 8'h60, 0);
		check(txStaticCfg, 32'h6161_0061, "gated broadcast");
		w(4'hD, 8'h81, 0);
		check(txStaticCfg, 32'h8181_8081, "forced broadcast");
		w(4'hF, 8'hFE, 0);
		w(4'hC, 8'h21, 0);
		check(rxStaticCfg, 32'h2121_2121, "force, mask bit zero clear");
		$display("test broadcast done");
		w(4'hF, 8'hFF, 0);
		@(posedge sys_clk);
		charStrobe <= 4'h1;
		commaHit <= 4'h1;
		hitOffset <= 16'h0005;
		@(posedge sys_clk);
		charStrobe <= 4'h0;
		#1;
		check({realign, stretchClock, alignOffset[3:0]}, 32'h0000_0115, "comma reframe");
		w(4'h0, 8'h05, 0);
		@(posedge sys_clk);
		charStrobe <= 4'h1;
		hitOffset <= 16'h0007;
		@(posedge sys_clk);
		#1;
		check(realign, 32'h0000_0000, "single hit");
		@(posedge sys_clk);
		charStrobe <= 4'h0;
		#1;
		check({realign, stretchClock, alignOffset[3:0]}, 32'h0000_0107, "pair reframe");
		w(4'h0, 8'h03, 0);
		check({reframeModeSel, framingCharSel}, 32'h0000_0010, "framer selects");
		@(posedge sys_clk);
		charStrobe <= 4'h1;
		hitOffset <= 16'h0002;
		for (int i = 1; i <= 4; i++) begin
			@(posedge sys_clk);
			if (i == 4) begin
				charStrobe <= 4'h0;
			end
			#1;
			check(realign, {31'h0, i == 4}, "adjacent run");
		end
		w(4'h0, 8'h09, 0);
		@(posedge sys_clk);
		charStrobe <= 4'h1;
		hitOffset <= 16'h0009;
		@(posedge sys_clk);
		k28Hit <= 4'h1;
		commaHit <= 4'h0;
		#1;
		check(realign, 32'h0000_0000, "comma ignored");
		@(posedge sys_clk);
		charStrobe <= 4'h0;
		#1;
		check({realign, stretchClock, alignOffset[3:0]}, 32'h0000_0119, "k28 reframe");
		$display("test framer done");
		w(4'hE, 8'h40, 1);
		check(dynamicCfg, 32'h4141_4141, "live controls");
		w(4'hE, 8'h80, 1);
		check(dynamicCfg, 32'h8181_8181, "live controls");
		w(4'hE, 8'h10, 0);
		check(dynamicCfg, 32'h1111_1111, "live controls");
		check(globalCfg, 32'h0010_8121, "global banks");
		$display("test live done");
		conclude();
	end
endmodule // tb_top
